// ### rtl/adcr_regs.sv
// Behaviour
// RULE1: Identification reads channel count three, bits 11:8
// RULE2: Host ignores identification low byte contents
// RULE3: Status register at index one, resets 0500h
// RULE4: Bit 15 shows serial interface locked
// RULE5: Bit 14 set on each resynchronization
// RULE6: Bit 13 set when register-map checksum changes
// RULE7: Bit 12 set on input frame checksum error
// RULE8: Bit 11 shows checksum polynomial, CCITT default
// RULE9: Bit 10 shows reset occurred, one after reset
// RULE10: Bits 9:8 show data word length
// RULE11: Bits 2:0 show per-channel new data
// RULE12: Mode register at index two, resets 0510h
// RULE13: Writing mode bit 10 zero clears reset flag
// RULE14: Mode bits 13,12 enable map, input checksums
// RULE15: Mode bits 3:2 choose data-ready pin source
// RULE16: Timeout enable, ready pin tristate and pulse
// RULE17: Status type and length mirror mode fields
// RULE18: Reserved status zero; read-only writes ignored
`timescale 1ns/1ps
module adcr_regs
  import adcr_pkg::*;
#(
  parameter logic [3:0] ID_UPPER    = 4'h0,
  parameter logic [7:0] ID_REVISION = 8'h00
) (
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire adcr_conv_t  conv,
  output adcr_mode_t       modeOut,
  output logic             readyPinOut,
  output logic             readyPinOe
);
  // ID_UPPER and ID_REVISION values are arbitrary

  adcr_mode_t  mode_ff;
  adcr_mode_t  nxt_mode;
  logic        lock_ff;
  logic        nxt_lock;
  logic        resyncFlag_ff;
  logic        nxt_resyncFlag;
  logic        regMapFlag_ff;
  logic        nxt_regMapFlag;
  logic        crcErrFlag_ff;
  logic        nxt_crcErrFlag;
  logic [2:0]  newDataFlag_ff;
  logic [2:0]  nxt_newDataFlag;
  logic [15:0] crcBase_ff;
  logic [15:0] nxt_crcBase;
  logic        wrPend_ff;
  logic        nxt_wrPend;
  logic [7:0]  wrIdx_ff;
  logic [7:0]  nxt_wrIdx;
  logic [31:0] hrdata_ff;
  logic [31:0] nxt_hrdata;
  logic        accept;
  logic        rdAccept;
  logic [7:0]  aIdx;
  logic        modeWrite;
  logic        statusRead;
  logic [15:0] statusNow;

  function automatic logic [15:0] buildStatus(
    input logic       lock,
    input logic       resync,
    input logic       regMap,
    input logic       crcErr,
    input adcr_mode_t mode,
    input logic [2:0] newData
  );
    logic [15:0] s;
    s = 16'h0000; // [RULE18]
    s[ST_LOCK]    = lock; // [RULE4]
    s[ST_RESYNC]  = resync; // [RULE5]
    s[ST_REGMAP]  = regMap; // [RULE6]
    s[ST_CRCERR]  = crcErr; // [RULE7]
    s[ST_CRCTYPE] = mode.crcAnsi; // [RULE8] [RULE17]
    s[ST_RESET]   = mode.resetFlag; // [RULE9]
    s[ST_WLEN_LSB +: 2] = mode.wordLengthSelect; // [RULE10] [RULE17]
    s[NUM_CH-1:0] = newData; // [RULE11]
    return s;
  endfunction

  // Bus address phase decode
  always_comb begin
    accept   = hsel & hready & (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
    rdAccept = accept & ~hwrite;
    aIdx     = haddr[ADDR_IDX_MSB:ADDR_IDX_LSB];
  end

  always_comb begin
    nxt_wrPend = accept & hwrite & (hsize == HSIZE_WORD);
    nxt_wrIdx  = accept ? aIdx : wrIdx_ff;
    modeWrite  = wrPend_ff & (wrIdx_ff == IDX_MODE); // [RULE18]
    statusRead = rdAccept & (aIdx == IDX_STATUS);
  end

  // Mode register
  always_comb begin
    nxt_mode = mode_ff;
    if (modeWrite) begin
      nxt_mode = adcr_mode_t'(hwdata[15:0]); // [RULE12] [RULE14] [RULE16]
      // Reset flag is clear-only from software
      nxt_mode.resetFlag = mode_ff.resetFlag & hwdata[ST_RESET]; // [RULE13]
    end
  end

  // Status flags; a set wins over a read clear
  always_comb begin
    nxt_lock       = conv.ifaceLocked; // [RULE4]
    nxt_resyncFlag = conv.resyncPulse | (resyncFlag_ff & ~statusRead); // [RULE5]
    nxt_crcErrFlag = (conv.rxCrcErrorPulse & mode_ff.rxCrcEnable) // [RULE7] [RULE14]
                     | (crcErrFlag_ff & ~statusRead);
    nxt_crcBase    = crcBase_ff;
    nxt_regMapFlag = regMapFlag_ff & ~statusRead;
    if (!mode_ff.regCrcEnable) begin
      nxt_crcBase    = conv.regMapCrc; // [RULE14]
      nxt_regMapFlag = 1'b0;
    end else if (conv.regMapCrc != crcBase_ff) begin
      nxt_crcBase    = conv.regMapCrc;
      nxt_regMapFlag = 1'b1; // [RULE6]
    end
    nxt_newDataFlag = conv.newDataPulse | (newDataFlag_ff & ~conv.dataTakenPulse); // [RULE11]
  end

  // Read data, with a pending mode write forwarded
  always_comb begin
    statusNow  = buildStatus(lock_ff, resyncFlag_ff, regMapFlag_ff, crcErrFlag_ff,
                             nxt_mode, newDataFlag_ff);
    nxt_hrdata = hrdata_ff;
    if (rdAccept) begin
      case (aIdx)
        IDX_IDENT:  nxt_hrdata = {16'h0000, ID_UPPER, CHANNEL_COUNT, ID_REVISION}; // [RULE1]
        IDX_STATUS: nxt_hrdata = {16'h0000, statusNow}; // [RULE3]
        IDX_MODE:   nxt_hrdata = {16'h0000, nxt_mode};
        default:    nxt_hrdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      mode_ff        <= adcr_mode_t'(MODE_RESET); // [RULE12]
      lock_ff        <= STATUS_RESET[ST_LOCK]; // [RULE3]
      resyncFlag_ff  <= STATUS_RESET[ST_RESYNC];
      regMapFlag_ff  <= STATUS_RESET[ST_REGMAP];
      crcErrFlag_ff  <= STATUS_RESET[ST_CRCERR];
      newDataFlag_ff <= 3'h0;
      crcBase_ff     <= 16'h0000;
      wrPend_ff      <= 1'b0;
      wrIdx_ff       <= 8'h00;
      hrdata_ff      <= 32'h0000_0000;
    end else begin
      mode_ff        <= nxt_mode;
      lock_ff        <= nxt_lock;
      resyncFlag_ff  <= nxt_resyncFlag;
      regMapFlag_ff  <= nxt_regMapFlag;
      crcErrFlag_ff  <= nxt_crcErrFlag;
      newDataFlag_ff <= nxt_newDataFlag;
      crcBase_ff     <= nxt_crcBase;
      wrPend_ff      <= nxt_wrPend;
      wrIdx_ff       <= nxt_wrIdx;
      hrdata_ff      <= nxt_hrdata;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_ff;
  assign modeOut   = mode_ff;

  adcr_ready_pin #(
    .PULSE_CYC (READY_PULSE_CYC)
  ) u_ready_pin (
    .ref_clk      (ref_clk),
    .nrst         (nrst),
    .newFlags     (newDataFlag_ff),
    .chEnable     (conv.chEnable),
    .sourceSelect (mode_ff.readyPinSourceSelect), // [RULE15]
    .idleTristate (mode_ff.readyPinIdleTristate),
    .pulseFormat  (mode_ff.readyPinPulseFormat),
    .pinOut       (readyPinOut),
    .pinOe        (readyPinOe)
  );

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence s_rd_idx(logic [7:0] idx);
    rdAccept && aIdx == idx;
  endsequence

  a_ident_count: assert property ( // [RULE1]
    s_rd_idx(IDX_IDENT) |=> hrdata[11:8] == 4'h3 && hrdata[31:16] == 16'h0000)
    else $error("identification channel count wrong");
  a_status_after_reset: assert property ( // [RULE3]
    $rose(nrst) |-> {16'h0000, buildStatus(lock_ff, resyncFlag_ff, regMapFlag_ff,
      crcErrFlag_ff, mode_ff, newDataFlag_ff)} == 32'h0000_0500 || lock_ff)
    else $error("status value after reset wrong");
  a_lock_follow: assert property ( // [RULE4]
    conv.ifaceLocked ##1 s_rd_idx(IDX_STATUS) |=> hrdata[15])
    else $error("lock bit not reported");
  a_resync_sticky: assert property ( // [RULE5]
    conv.resyncPulse |=> resyncFlag_ff until_with (statusRead && !conv.resyncPulse))
    else $error("resync flag lost before read");
  a_regmap_change: assert property ( // [RULE6]
    mode_ff.regCrcEnable && conv.regMapCrc != crcBase_ff |=> regMapFlag_ff)
    else $error("map checksum change not flagged");
  a_crcerr_gate: assert property ( // [RULE7] [RULE14]
    conv.rxCrcErrorPulse && !crcErrFlag_ff |=> crcErrFlag_ff == $past(mode_ff.rxCrcEnable))
    else $error("input checksum error flag gating wrong");
  a_mode_reset: assert property ( // [RULE12]
    $rose(nrst) |-> mode_ff == adcr_mode_t'(16'h0510))
    else $error("mode value after reset wrong");
  a_reset_clear: assert property ( // [RULE13] [RULE9]
    modeWrite && !hwdata[ST_RESET] |=> !mode_ff.resetFlag ##1 !mode_ff.resetFlag)
    else $error("reset flag not cleared by mode write");
  a_reset_noset: assert property ( // [RULE13]
    !mode_ff.resetFlag |=> !mode_ff.resetFlag)
    else $error("reset flag set by software");
  a_mirror_fields: assert property ( // [RULE17] [RULE8] [RULE10]
    s_rd_idx(IDX_STATUS) |=> hrdata[11] == mode_ff.crcAnsi && hrdata[9:8] ==
      mode_ff.wordLengthSelect)
    else $error("status does not mirror mode fields");
  a_reserved_zero: assert property ( // [RULE18]
    s_rd_idx(IDX_STATUS) |=> hrdata[7:3] == 5'h00)
    else $error("reserved status bits not zero");
  a_newdata_set: assert property ( // [RULE11]
    conv.newDataPulse[0] |=> newDataFlag_ff[0])
    else $error("channel 0 new data not flagged");
  a_ro_write: assert property ( // [RULE18]
    wrPend_ff && wrIdx_ff != IDX_MODE |=> $stable(mode_ff))
    else $error("write to read-only register changed mode");

endmodule

// ### rtl/adcr_pkg.sv
package adcr_pkg;

  // Register indices; byte address is index times four
  localparam logic [7:0]  IDX_IDENT       = 8'h00;
  localparam logic [7:0]  IDX_STATUS      = 8'h01;
  localparam logic [7:0]  IDX_MODE        = 8'h02;
  localparam int unsigned ADDR_IDX_LSB    = 2;
  localparam int unsigned ADDR_IDX_MSB    = 9;

  // Identification fields
  localparam logic [3:0]  CHANNEL_COUNT   = 4'h3;
  localparam int unsigned NUM_CH          = 3;

  // Values after reset
  localparam logic [15:0] STATUS_RESET    = 16'h0500;
  localparam logic [15:0] MODE_RESET      = 16'h0510;

  // Status field positions
  localparam int unsigned ST_LOCK         = 15;
  localparam int unsigned ST_RESYNC       = 14;
  localparam int unsigned ST_REGMAP       = 13;
  localparam int unsigned ST_CRCERR       = 12;
  localparam int unsigned ST_CRCTYPE      = 11;
  localparam int unsigned ST_RESET        = 10;
  localparam int unsigned ST_WLEN_LSB     = 8;

  // Data-ready pulse timing
  localparam int unsigned CLK_PERIOD_NS   = 20;
  localparam int unsigned READY_PULSE_NS  = 80;
  localparam int unsigned READY_PULSE_CYC =
    (READY_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // AHB codes
  localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
  localparam logic [1:0]  HTRANS_SEQ      = 2'h3;
  localparam logic [2:0]  HSIZE_WORD      = 3'h2;

  typedef struct packed {
    logic       reservedHi;
    logic       reservedHi0;
    logic       regCrcEnable;
    logic       rxCrcEnable;
    logic       crcAnsi;
    logic       resetFlag;
    logic [1:0] wordLengthSelect;
    logic [2:0] reservedLo;
    logic       timeoutEnable;
    logic [1:0] readyPinSourceSelect;
    logic       readyPinIdleTristate;
    logic       readyPinPulseFormat;
  } adcr_mode_t;

  typedef struct packed {
    logic        ifaceLocked;
    logic        resyncPulse;
    logic        rxCrcErrorPulse;
    logic [15:0] regMapCrc;
    logic [2:0]  newDataPulse;
    logic [2:0]  dataTakenPulse;
    logic [2:0]  chEnable;
  } adcr_conv_t;

  typedef enum logic [2:0] {
    RDY_IDLE  = 3'b001,
    RDY_PULSE = 3'b010,
    RDY_HOLD  = 3'b100
  } adcr_rdy_state_t;

endpackage

// ### rtl/adcr_ready_pin.sv
`timescale 1ns/1ps
module adcr_ready_pin
  import adcr_pkg::*;
#(
  parameter int unsigned PULSE_CYC = READY_PULSE_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic [2:0]  newFlags,
  input  wire logic [2:0]  chEnable,
  input  wire logic [1:0]  sourceSelect,
  input  wire logic        idleTristate,
  input  wire logic        pulseFormat,
  output logic             pinOut,
  output logic             pinOe
);

  adcr_rdy_state_t state_ff;
  adcr_rdy_state_t nxt_state;
  logic [7:0]      count_ff;
  logic [7:0]      nxt_count;
  logic            pinOut_ff;
  logic            nxt_pinOut;
  logic            pinOe_ff;
  logic            nxt_pinOe;
  logic            pending;
  logic            anyEnabled;

  always_comb begin
    anyEnabled = |chEnable;
    case (sourceSelect)
      2'h0:    pending = anyEnabled & (&(newFlags | ~chEnable)); // [RULE15]
      default: pending = |(newFlags & chEnable); // [RULE15]
    endcase
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_count = count_ff;
    case (state_ff)
      RDY_IDLE: begin
        if (pending && pulseFormat) begin
          nxt_state = RDY_PULSE;
          nxt_count = 8'(PULSE_CYC - 1);
        end else if (pending) begin
          nxt_state = RDY_HOLD;
        end
      end
      RDY_PULSE: begin
        if (count_ff == 8'h00) begin
          nxt_state = RDY_HOLD;
        end else begin
          nxt_count = count_ff - 8'h01;
        end
      end
      RDY_HOLD: begin
        if (!pending) begin
          nxt_state = RDY_IDLE;
        end
      end
      default: nxt_state = RDY_IDLE;
    endcase
    // Low while asserted; idle high or released
    if (nxt_state == RDY_PULSE || (nxt_state == RDY_HOLD && !pulseFormat)) begin
      nxt_pinOut = 1'b0; // [RULE16]
      nxt_pinOe  = 1'b1;
    end else begin
      nxt_pinOut = 1'b1;
      nxt_pinOe  = ~idleTristate; // [RULE16]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      state_ff  <= RDY_IDLE;
      count_ff  <= 8'h00;
      pinOut_ff <= 1'b1;
      pinOe_ff  <= 1'b1;
    end else begin
      state_ff  <= nxt_state;
      count_ff  <= nxt_count;
      pinOut_ff <= nxt_pinOut;
      pinOe_ff  <= nxt_pinOe;
    end
  end

  assign pinOut = pinOut_ff;
  assign pinOe  = pinOe_ff;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  a_pulse_low_len: assert property ( // [RULE16]
    $rose(state_ff == RDY_PULSE) |-> (!pinOut_ff)[*4])
    else $error("ready pulse shorter than expected");
  a_hiz_idle_release: assert property ( // [RULE16]
    (state_ff == RDY_IDLE && idleTristate && !pending) |=> !pinOe_ff)
    else $error("ready pin driven while idle in tristate mode");

endmodule

// ### test/adcr_host.sv
`timescale 1ns/1ps
module adcr_host
  import adcr_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = HSIZE_WORD;
    hwdata = 32'h0000_0000;
  end

  // Waits for hready, bounded
  task automatic waitReady();
    int n;
    n = 0;
    @(posedge ref_clk);
    while (hready !== 1'b1 && n < 50) begin
      n++;
      @(posedge ref_clk);
    end
    if (n >= 50) adcr_regs_tb.timeoutHit();
  endtask

  // One word transfer; ident low byte never relied on
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [15:0] wd,
                      output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'h0};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= HSIZE_WORD;
    waitReady();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {16'h0000, wd};
    waitReady();
    rd = hrdata;
  endtask
endmodule

// ### test/adcr_regs_tb.sv
`timescale 1ns/1ps
module adcr_regs_tb
  import adcr_pkg::*;
;
  logic        ref_clk;
  logic        nrst;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  adcr_conv_t  conv;
  adcr_mode_t  modeOut;
  logic        readyPinOut;
  logic        readyPinOe;
  logic [31:0] v;
  int          errors;
  int          compares;

  adcr_regs i_dut (.ref_clk(ref_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .conv(conv), .modeOut(modeOut),
    .readyPinOut(readyPinOut), .readyPinOe(readyPinOe));

  adcr_host i_host (.ref_clk(ref_clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("Counts: %0d compares, %0d errors", compares, errors);
    if (errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic timeoutHit();
    errors++;
    $display("unexpected at %0t: bus wait timed out", $time);
    complete_run();
  endtask

  task automatic rd(input logic [7:0] idx);
    i_host.xfer(1'b0, idx, 16'h0000, v);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [15:0] d);
    logic [31:0] unused;
    i_host.xfer(1'b1, idx, d, unused);
  endtask

  // Pulse event bits for one cycle, then wait for the pin stage
  task automatic evt(input logic rs, input logic ce, input logic [2:0] nd,
                     input logic [2:0] tk);
    conv.resyncPulse <= rs;
    conv.rxCrcErrorPulse <= ce;
    conv.newDataPulse <= nd;
    conv.dataTakenPulse <= tk;
    @(posedge ref_clk);
    conv.resyncPulse <= 1'b0;
    conv.rxCrcErrorPulse <= 1'b0;
    conv.newDataPulse <= 3'h0;
    conv.dataTakenPulse <= 3'h0;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask

  task automatic resetTest();
    rd(IDX_IDENT);
    check(v[11:8], CHANNEL_COUNT);
    rd(IDX_STATUS);
    check(v, {16'h0000, STATUS_RESET});
    rd(IDX_MODE);
    check(v, {16'h0000, MODE_RESET});
    wr(IDX_IDENT, 16'hFFFF);
    wr(IDX_STATUS, 16'hFFFF);
    rd(IDX_IDENT);
    check(v[11:8], CHANNEL_COUNT);
    rd(IDX_STATUS);
    check(v, {16'h0000, STATUS_RESET});
    check({hresp, hreadyout}, 2'h1);
    rd(8'h03);
    check(v, 32'h0000_0000);
    $display("Test reset values done");
  endtask

  task automatic lengthTest();
    logic [1:0] i;
    for (int k = 0; k < 4; k++) begin
      i = k[1:0];
      wr(IDX_MODE, {4'h0, i[0], 1'b0, i, 8'h10});
      rd(IDX_STATUS);
      check(v, {20'h0, i[0], 1'b0, i, 8'h00});
      check(modeOut, {4'h0, i[0], 1'b0, i, 8'h10});
    end
    wr(IDX_MODE, MODE_RESET);
    rd(IDX_STATUS);
    check(v[10], 1'b0);
    $display("Test word length and type done");
  endtask

  task automatic eventTest();
    conv.ifaceLocked <= 1'b1;
    evt(1'b1, 1'b1, 3'h0, 3'h0);
    rd(IDX_STATUS);
    check(v[15:12], 4'hC);
    rd(IDX_STATUS);
    check(v[14], 1'b0);
    wr(IDX_MODE, 16'h3010);
    evt(1'b0, 1'b1, 3'h0, 3'h0);
    conv.regMapCrc <= 16'h1234;
    evt(1'b0, 1'b0, 3'h0, 3'h0);
    rd(IDX_STATUS);
    check(v[15:12], 4'hB);
    rd(IDX_STATUS);
    check(v[13:12], 2'h0);
    conv.ifaceLocked <= 1'b0;
    wr(IDX_MODE, 16'h0010);
    rd(IDX_STATUS);
    check(v[15], 1'b0);
    $display("Test status events done");
  endtask

  task automatic newDataTest();
    evt(1'b0, 1'b0, 3'h2, 3'h0);
    rd(IDX_STATUS);
    check(v[7:0], 8'h02);
    rd(IDX_STATUS);
    check(v[2:0], 3'h2);
    evt(1'b0, 1'b0, 3'h0, 3'h2);
    rd(IDX_STATUS);
    check(v[2:0], 3'h0);
    $display("Test new data flags done");
  endtask

  task automatic pinTest();
    int n;
    wr(IDX_MODE, 16'h0014);
    evt(1'b0, 1'b0, 3'h1, 3'h0);
    check({readyPinOut, readyPinOe}, 2'h1);
    evt(1'b0, 1'b0, 3'h0, 3'h1);
    check({readyPinOut, readyPinOe}, 2'h3);
    wr(IDX_MODE, 16'h0010);
    evt(1'b0, 1'b0, 3'h1, 3'h0);
    check(readyPinOut, 1'b1);
    evt(1'b0, 1'b0, 3'h6, 3'h0);
    check(readyPinOut, 1'b0);
    evt(1'b0, 1'b0, 3'h0, 3'h7);
    wr(IDX_MODE, 16'h0015);
    conv.newDataPulse <= 3'h1;
    @(posedge ref_clk);
    conv.newDataPulse <= 3'h0;
    n = 0;
    repeat (10) begin
      @(posedge ref_clk);
      #1;
      if (readyPinOut === 1'b0) n++;
    end
    check(n, READY_PULSE_CYC);
    evt(1'b0, 1'b0, 3'h0, 3'h1);
    wr(IDX_MODE, 16'h0012);
    evt(1'b0, 1'b0, 3'h0, 3'h0);
    check(readyPinOe, 1'b0);
    evt(1'b0, 1'b0, 3'h4, 3'h0);
    check({readyPinOut, readyPinOe}, 2'h2);
    evt(1'b0, 1'b0, 3'h3, 3'h0);
    check({readyPinOut, readyPinOe}, 2'h1);
    $display("Test ready pin done");
  endtask

  task automatic reResetTest();
    nrst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    #1;
    check({readyPinOut, readyPinOe}, 2'h3);
    @(posedge ref_clk);
    rd(IDX_STATUS);
    check(v, {16'h0000, STATUS_RESET});
    rd(IDX_MODE);
    check(v, {16'h0000, MODE_RESET});
    $display("Test second reset done");
  endtask

  initial begin
    errors = 0;
    compares = 0;
    nrst = 1'b0;
    conv = '0;
    conv.chEnable = 3'h7;
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    resetTest();
    lengthTest();
    eventTest();
    newDataTest();
    pinTest();
    reResetTest();
    complete_run();
  end
endmodule
